// *** hdl/mpfv_pkg.sv ***
// Constants, register map and carrier types for the pause, flow and VLAN block
package mpfv_pkg;
    localparam int unsigned CLK_MHZ = 250;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_ACC = 6'h06;
    localparam logic [5:0] IDX_DATA = 6'h07;
    localparam logic [5:0] IDX_FLOW = 6'h08;
    localparam logic [5:0] IDX_VLAN = 6'h09;
    localparam logic [5:0] IDX_CTRL = 6'h10;
    localparam logic [31:0] REG_RST = 32'h0000_0000;
    localparam int FLOW_TIME_LSB = 16;
    localparam int FLOW_FWD_BIT = 2;
    localparam int FLOW_EN_BIT = 1;
    localparam int ACC_ADDR_LSB = 11;
    localparam int ACC_IDX_LSB = 6;
    localparam int ACC_WR_BIT = 1;
    localparam int ACC_PEND_BIT = 0;
    localparam int CTRL_TXEN_BIT = 0;
    localparam int CTRL_FD_BIT = 1;
    localparam int CTRL_SPD_BIT = 2;
    localparam int CTRL_REQ_BIT = 3;
    // Control frame layout
    localparam logic [47:0] PAUSE_DA = 48'h0180_C200_0001;
    localparam logic [15:0] ETH_TYPE_CTRL = 16'h8808;
    localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
    localparam logic [5:0] POS_SA = 6'h06;
    localparam logic [5:0] POS_TYPE = 6'h0C;
    localparam logic [5:0] POS_OP = 6'h0E;
    localparam logic [5:0] POS_TIME = 6'h10;
    localparam logic [5:0] PAUSE_LAST = 6'h3B;
    localparam logic [11:0] MAX_LEN = 12'h5EE;
    localparam logic [11:0] MAX_LEN_VLAN = 12'h5F2;
    // Slot time is 512 bit times
    localparam int unsigned SLOT_BITS = 512;
    localparam int unsigned BIT_NS_100 = 10;
    localparam int unsigned BIT_NS_10 = 100;
    localparam int unsigned SLOT_CYC_100 = SLOT_BITS * BIT_NS_100 * CLK_MHZ / 1000;
    localparam int unsigned SLOT_CYC_10 = SLOT_BITS * BIT_NS_10 * CLK_MHZ / 1000;
    typedef struct packed {
        logic [7:0] data;
        logic sof;
        logic eof;
        logic err;
    } mpfv_rx_beat_t;
    typedef struct packed {
        logic [7:0] data;
        logic last;
    } mpfv_tx_beat_t;
    typedef struct packed {
        logic valid;
        logic pause;
        logic [15:0] ptime;
        logic vlan;
        logic too_long;
        logic err;
    } mpfv_rx_sum_t;
    typedef struct packed {
        logic valid;
        logic filter;
        logic vlan;
        logic too_long;
        logic err;
    } mpfv_rx_stat_t;
endpackage

// *** hdl/mpfv_rx_parse.sv ***
// Receive frame parser: control frame decode, VLAN detect, length check
`timescale 1ns/10ps
module mpfv_rx_parse (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic rx_valid,
    input wire mpfv_pkg::mpfv_rx_beat_t rx_beat,
    input wire logic [15:0] vlan_tag,
    output mpfv_pkg::mpfv_rx_sum_t sum
);
    logic [11:0] cnt_r, cnt_nxt, idx, len;
    logic [15:0] type_r, type_nxt, op_r, op_nxt, time_r, time_nxt;
    mpfv_pkg::mpfv_rx_sum_t sum_r, sum_nxt;

    always_comb begin
        idx = rx_beat.sof ? 12'h000 : cnt_r;
        len = idx + 12'h001;
        cnt_nxt = cnt_r;
        type_nxt = type_r;
        op_nxt = op_r;
        time_nxt = time_r;
        sum_nxt = '0;
        if (rx_valid) begin
            if (idx != 12'hFFF) begin
                cnt_nxt = len;
            end
            case (idx)
                {6'h00, mpfv_pkg::POS_TYPE}: type_nxt[15:8] = rx_beat.data;
                {6'h00, mpfv_pkg::POS_TYPE} + 12'h001: type_nxt[7:0] = rx_beat.data;
                {6'h00, mpfv_pkg::POS_OP}: op_nxt[15:8] = rx_beat.data;
                {6'h00, mpfv_pkg::POS_OP} + 12'h001: op_nxt[7:0] = rx_beat.data;
                {6'h00, mpfv_pkg::POS_TIME}: time_nxt[15:8] = rx_beat.data;
                {6'h00, mpfv_pkg::POS_TIME} + 12'h001: time_nxt[7:0] = rx_beat.data;
                default: ;
            endcase
            if (rx_beat.eof) begin
                sum_nxt.valid = 1'b1;
                sum_nxt.err = rx_beat.err;
                sum_nxt.vlan = (type_nxt == vlan_tag);
                sum_nxt.pause = (type_nxt == mpfv_pkg::ETH_TYPE_CTRL) && (op_nxt == mpfv_pkg::PAUSE_OPCODE);
                sum_nxt.ptime = time_nxt;
                sum_nxt.too_long = len > (sum_nxt.vlan ? mpfv_pkg::MAX_LEN_VLAN : mpfv_pkg::MAX_LEN);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_r <= '0;
            type_r <= '0;
            op_r <= '0;
            time_r <= '0;
            sum_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
            type_r <= type_nxt;
            op_r <= op_nxt;
            time_r <= time_nxt;
            sum_r <= sum_nxt;
        end
    end

    assign sum = sum_r;

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    vlan_len_ok_a: assert property (rx_valid && rx_beat.eof && len == mpfv_pkg::MAX_LEN_VLAN
        && type_nxt == vlan_tag |=> sum.valid && !sum.too_long) else $error("tagged 1522 byte frame flagged long");
    plain_len_bad_a: assert property (rx_valid && rx_beat.eof && len == mpfv_pkg::MAX_LEN + 12'h001
        && type_nxt != vlan_tag |=> sum.too_long) else $error("untagged 1519 byte frame not flagged");
endmodule

// *** hdl/mpfv_pause_gen.sv ***
// Pause control frame generator, one byte per accepted beat
`timescale 1ns/10ps
module mpfv_pause_gen (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [15:0] pause_time,
    input wire logic [47:0] src_addr,
    output logic tx_valid,
    output mpfv_pkg::mpfv_tx_beat_t tx_beat,
    input wire logic tx_ready,
    output logic busy
);
    typedef enum logic [1:0] {MPFV_G_IDLE = 2'b01, MPFV_G_SEND = 2'b10} mpfv_gen_state_t;
    mpfv_gen_state_t st_r, st_nxt;
    logic [5:0] idx_r, idx_nxt;
    logic [15:0] time_r, time_nxt;
    mpfv_pkg::mpfv_tx_beat_t beat_r, beat_nxt;

    function automatic logic [7:0] byte_at(input logic [5:0] i, input logic [15:0] t, input logic [47:0] sa);
        logic [47:0] sh;
        sh = '0;
        if (i < mpfv_pkg::POS_SA) begin
            sh = mpfv_pkg::PAUSE_DA << (i * 8);
        end else if (i < mpfv_pkg::POS_TYPE) begin
            sh = sa << ((i - mpfv_pkg::POS_SA) * 8);
        end else if (i < mpfv_pkg::POS_OP) begin
            sh = {mpfv_pkg::ETH_TYPE_CTRL, 32'h0000_0000} << ((i - mpfv_pkg::POS_TYPE) * 8);
        end else if (i < mpfv_pkg::POS_TIME) begin
            sh = {mpfv_pkg::PAUSE_OPCODE, 32'h0000_0000} << ((i - mpfv_pkg::POS_OP) * 8);
        end else if (i < mpfv_pkg::POS_TIME + 6'h02) begin
            sh = {t, 32'h0000_0000} << ((i - mpfv_pkg::POS_TIME) * 8);
        end
        return sh[47:40];
    endfunction

    always_comb begin
        st_nxt = st_r;
        idx_nxt = idx_r;
        time_nxt = time_r;
        beat_nxt = beat_r;
        case (st_r)
            MPFV_G_IDLE: begin
                if (start) begin
                    st_nxt = MPFV_G_SEND;
                    idx_nxt = '0;
                    time_nxt = pause_time;
                    beat_nxt.data = byte_at(6'h00, pause_time, src_addr);
                    beat_nxt.last = 1'b0;
                end
            end
            MPFV_G_SEND: begin
                if (tx_ready) begin
                    if (beat_r.last) begin
                        st_nxt = MPFV_G_IDLE;
                    end else begin
                        idx_nxt = idx_r + 6'h01;
                        beat_nxt.data = byte_at(idx_nxt, time_r, src_addr);
                        beat_nxt.last = (idx_nxt == mpfv_pkg::PAUSE_LAST);
                    end
                end
            end
            default: st_nxt = MPFV_G_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_r <= MPFV_G_IDLE;
            idx_r <= '0;
            time_r <= '0;
            beat_r <= '0;
        end else begin
            st_r <= st_nxt;
            idx_r <= idx_nxt;
            time_r <= time_nxt;
            beat_r <= beat_nxt;
        end
    end

    assign tx_valid = (st_r == MPFV_G_SEND);
    assign tx_beat = beat_r;
    assign busy = (st_r == MPFV_G_SEND);

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    frame_time_a: assert property (tx_valid && idx_r == mpfv_pkg::POS_TIME |-> tx_beat.data == time_r[15:8])
        else $error("pause time byte wrong");
    frame_type_a: assert property (tx_valid && idx_r == mpfv_pkg::POS_TYPE |-> tx_beat.data == mpfv_pkg::ETH_TYPE_CTRL[15:8])
        else $error("control type byte wrong");
endmodule

// *** hdl/mpfv_flow_ctl.sv ***
// Flow control, management data and VLAN register block with Avalon-MM slave
`timescale 1ns/10ps
module mpfv_flow_ctl #(
    parameter int unsigned SLOT_CYC_10 = mpfv_pkg::SLOT_CYC_10
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic rx_valid,
    input wire mpfv_pkg::mpfv_rx_beat_t rx_beat,
    input wire logic addr_pass,
    input wire logic promisc,
    output logic rxo_valid,
    output mpfv_pkg::mpfv_rx_beat_t rxo_beat,
    output mpfv_pkg::mpfv_rx_stat_t rx_stat,
    input wire logic [47:0] mac_addr,
    output logic tx_valid,
    output mpfv_pkg::mpfv_tx_beat_t tx_beat,
    input wire logic tx_ready,
    output logic tx_halt,
    output logic backpressure,
    output logic tx_enable,
    output logic full_duplex,
    output logic speed_100,
    output logic mgmt_start,
    output logic mgmt_write,
    output logic [4:0] mgmt_phy_addr,
    output logic [4:0] mgmt_reg_idx,
    output logic [15:0] mgmt_wdata,
    input wire logic mgmt_done,
    input wire logic [15:0] mgmt_rdata
);
    logic req, hit, ack_r, ack_nxt, wr_now, gen_busy, gen_start, busy, pause_accept;
    logic [5:0] idx;
    logic [31:0] rd_r, rd_nxt, rd_mux, wmask;
    logic [15:0] data_r, data_nxt, time_r, time_nxt, vlan_r, vlan_nxt;
    logic fwd_r, fwd_nxt, en_r, en_nxt;
    logic [3:0] ctrl_r, ctrl_nxt;
    logic req_prev_r;
    logic [4:0] acc_addr_r, acc_addr_nxt, acc_idx_r, acc_idx_nxt;
    logic acc_wr_r, acc_wr_nxt, pend_r, pend_nxt, start_r, start_nxt;
    logic [15:0] pcnt_r, pcnt_nxt, slot_r, slot_nxt, slot_lim;
    mpfv_pkg::mpfv_rx_sum_t sum;
    mpfv_pkg::mpfv_rx_stat_t stat_r, stat_nxt;
    mpfv_pkg::mpfv_rx_beat_t pipe_r [2];
    logic [1:0] pipe_v_r;

    mpfv_rx_parse u_parse (
        .core_clk(core_clk),
        .rst(rst),
        .rx_valid(rx_valid),
        .rx_beat(rx_beat),
        .vlan_tag(vlan_r),
        .sum(sum)
    );

    mpfv_pause_gen u_gen (
        .core_clk(core_clk),
        .rst(rst),
        .start(gen_start),
        .pause_time(time_r),
        .src_addr(mac_addr),
        .tx_valid(tx_valid),
        .tx_beat(tx_beat),
        .tx_ready(tx_ready),
        .busy(gen_busy)
    );

    // Bus slave: one wait cycle, then the answer
    assign req = avs_read | avs_write;
    assign idx = avs_address[7:2];
    assign avs_waitrequest = req & ~ack_r;
    assign wr_now = avs_write & ack_r;
    assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign avs_readdata = rd_r;

    assign tx_enable = ctrl_r[mpfv_pkg::CTRL_TXEN_BIT];
    assign full_duplex = ctrl_r[mpfv_pkg::CTRL_FD_BIT];
    assign speed_100 = ctrl_r[mpfv_pkg::CTRL_SPD_BIT];
    assign backpressure = ~full_duplex & tx_enable & en_r & ctrl_r[mpfv_pkg::CTRL_REQ_BIT];
    assign gen_start = full_duplex & tx_enable & ctrl_r[mpfv_pkg::CTRL_REQ_BIT] & ~req_prev_r & ~gen_busy;
    assign busy = full_duplex ? gen_busy : backpressure;
    assign pause_accept = sum.valid & sum.pause & ~sum.err & full_duplex & en_r;
    assign slot_lim = speed_100 ? 16'(mpfv_pkg::SLOT_CYC_100) : 16'(SLOT_CYC_10);
    assign tx_halt = (pcnt_r != 16'h0000);

    always_comb begin
        hit = 1'b1;
        case (idx)
            mpfv_pkg::IDX_ACC: rd_mux = {16'h0000, acc_addr_r, acc_idx_r, 4'h0, acc_wr_r, pend_r};
            mpfv_pkg::IDX_DATA: rd_mux = {16'h0000, data_r};
            mpfv_pkg::IDX_FLOW: rd_mux = {time_r, 13'h0000, fwd_r, en_r, busy};
            mpfv_pkg::IDX_VLAN: rd_mux = {16'h0000, vlan_r};
            mpfv_pkg::IDX_CTRL: rd_mux = {28'h0000000, ctrl_r};
            default: begin
                rd_mux = mpfv_pkg::REG_RST;
                hit = 1'b0;
            end
        endcase
    end

    // Register file and management handshake
    always_comb begin
        logic [31:0] w;
        w = (rd_mux & ~wmask) | (avs_writedata & wmask);
        ack_nxt = req & ~ack_r;
        rd_nxt = (avs_read & ~ack_r) ? rd_mux : rd_r;
        data_nxt = data_r;
        time_nxt = time_r;
        fwd_nxt = fwd_r;
        en_nxt = en_r;
        vlan_nxt = vlan_r;
        ctrl_nxt = ctrl_r;
        acc_addr_nxt = acc_addr_r;
        acc_idx_nxt = acc_idx_r;
        acc_wr_nxt = acc_wr_r;
        pend_nxt = pend_r;
        start_nxt = 1'b0;
        if (wr_now && hit) begin
            case (idx)
                mpfv_pkg::IDX_ACC: begin
                    if (!pend_r) begin
                        acc_addr_nxt = w[mpfv_pkg::ACC_ADDR_LSB +: 5];
                        acc_idx_nxt = w[mpfv_pkg::ACC_IDX_LSB +: 5];
                        acc_wr_nxt = w[mpfv_pkg::ACC_WR_BIT];
                        pend_nxt = w[mpfv_pkg::ACC_PEND_BIT];
                        start_nxt = w[mpfv_pkg::ACC_PEND_BIT];
                    end
                end
                mpfv_pkg::IDX_DATA: begin
                    if (!pend_r) begin
                        data_nxt = w[15:0];
                    end
                end
                mpfv_pkg::IDX_FLOW: begin
                    time_nxt = w[mpfv_pkg::FLOW_TIME_LSB +: 16];
                    fwd_nxt = w[mpfv_pkg::FLOW_FWD_BIT];
                    en_nxt = w[mpfv_pkg::FLOW_EN_BIT];
                end
                mpfv_pkg::IDX_VLAN: vlan_nxt = w[15:0];
                mpfv_pkg::IDX_CTRL: ctrl_nxt = w[3:0];
                default: ;
            endcase
        end
        if (pend_r && mgmt_done) begin
            pend_nxt = 1'b0;
            if (!acc_wr_r) begin
                data_nxt = mgmt_rdata;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ack_r <= 1'b0;
            rd_r <= mpfv_pkg::REG_RST;
            data_r <= mpfv_pkg::REG_RST[15:0];
            time_r <= mpfv_pkg::REG_RST[31:16];
            fwd_r <= 1'b0;
            en_r <= 1'b0;
            vlan_r <= mpfv_pkg::REG_RST[15:0];
            ctrl_r <= mpfv_pkg::REG_RST[3:0];
            req_prev_r <= 1'b0;
            acc_addr_r <= '0;
            acc_idx_r <= '0;
            acc_wr_r <= 1'b0;
            pend_r <= 1'b0;
            start_r <= 1'b0;
        end else begin
            ack_r <= ack_nxt;
            rd_r <= rd_nxt;
            data_r <= data_nxt;
            time_r <= time_nxt;
            fwd_r <= fwd_nxt;
            en_r <= en_nxt;
            vlan_r <= vlan_nxt;
            ctrl_r <= ctrl_nxt;
            req_prev_r <= ctrl_r[mpfv_pkg::CTRL_REQ_BIT];
            acc_addr_r <= acc_addr_nxt;
            acc_idx_r <= acc_idx_nxt;
            acc_wr_r <= acc_wr_nxt;
            pend_r <= pend_nxt;
            start_r <= start_nxt;
        end
    end

    assign mgmt_start = start_r;
    assign mgmt_write = acc_wr_r;
    assign mgmt_phy_addr = acc_addr_r;
    assign mgmt_reg_idx = acc_idx_r;
    assign mgmt_wdata = data_r;

    // Pause timer and receive status
    always_comb begin
        pcnt_nxt = pcnt_r;
        slot_nxt = slot_r;
        if (pause_accept) begin
            pcnt_nxt = sum.ptime;
            slot_nxt = '0;
        end else if (pcnt_r != 16'h0000) begin
            if (slot_r >= slot_lim - 16'h0001) begin
                slot_nxt = '0;
                pcnt_nxt = pcnt_r - 16'h0001;
            end else begin
                slot_nxt = slot_r + 16'h0001;
            end
        end
        stat_nxt = '0;
        if (sum.valid) begin
            stat_nxt.valid = 1'b1;
            stat_nxt.vlan = sum.vlan;
            stat_nxt.too_long = sum.too_long;
            stat_nxt.err = sum.err;
            if (promisc) begin
                stat_nxt.filter = 1'b1;
            end else if (sum.pause && !sum.err) begin
                stat_nxt.filter = fwd_r;
            end else begin
                stat_nxt.filter = addr_pass;
            end
        end
    end

    // Received data is delayed so that its end lines up with the status word
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pcnt_r <= '0;
            slot_r <= '0;
            stat_r <= '0;
            pipe_v_r <= '0;
            pipe_r[0] <= '0;
            pipe_r[1] <= '0;
        end else begin
            pcnt_r <= pcnt_nxt;
            slot_r <= slot_nxt;
            stat_r <= stat_nxt;
            pipe_v_r <= {pipe_v_r[0], rx_valid};
            pipe_r[0] <= rx_beat;
            pipe_r[1] <= pipe_r[0];
        end
    end

    assign rxo_valid = pipe_v_r[1];
    assign rxo_beat = pipe_r[1];
    assign rx_stat = stat_r;

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    data_upper_a: assert property (avs_read && ack_r && idx == mpfv_pkg::IDX_DATA |-> avs_readdata[31:16] == 16'h0000)
        else $error("data register upper half not zero");
    busy_fd_a: assert property (gen_start |=> busy [*8])
        else $error("busy dropped during pause frame");
    busy_hd_a: assert property (avs_read && !ack_r && idx == mpfv_pkg::IDX_FLOW && !full_duplex
        |=> avs_readdata[0] == $past(backpressure)) else $error("busy bit not backpressure in half duplex");
    txdis_quiet_a: assert property (!tx_enable |-> !backpressure ##1 !$rose(tx_valid))
        else $error("flow action with transmitter off");
    fwd_mark_a: assert property (sum.valid && sum.pause && !sum.err && !promisc |=> rx_stat.filter == $past(fwd_r))
        else $error("pause filter bit not per forward flag");
    promisc_win_a: assert property (sum.valid && promisc |=> rx_stat.valid && rx_stat.filter)
        else $error("promiscuous did not override");
    halt_load_a: assert property (pause_accept && sum.ptime != 16'h0000 |=> tx_halt [*2])
        else $error("valid pause did not halt transmitter");
    no_decode_a: assert property (!en_r && pcnt_r == 16'h0000 |=> !tx_halt)
        else $error("pause acted on with enable clear");
    mgmt_hold_a: assert property (pend_r && wr_now && idx == mpfv_pkg::IDX_DATA && !mgmt_done
        |=> data_r == $past(data_r)) else $error("data register changed during access");
    slot_step_a: assert property (pcnt_r != 16'h0000 && !pause_accept && slot_r < slot_lim - 16'h0001
        |=> pcnt_r == $past(pcnt_r))
        else $error("pause count stepped before slot end");
    pause_sent_c: cover property (tx_valid && tx_beat.last && tx_ready);
    pause_rx_c: cover property (pause_accept);
    bp_c: cover property (backpressure);
    mgmt_c: cover property (pend_r && mgmt_done);
endmodule

// *** verification/mpfv_link_partner.sv ***
// Link partner model: takes pause frame bytes with periodic stalls
`timescale 1ns/10ps
module mpfv_link_partner (
    input wire logic core_clk,
    input wire logic tx_valid,
    input wire mpfv_pkg::mpfv_tx_beat_t tx_beat,
    output logic tx_ready
);
    logic [7:0] got [0:63];
    int n = 0;
    int ph = 0;
    initial tx_ready = 1'b0;
    always @(posedge core_clk) begin
        ph <= ph + 1;
        tx_ready <= (ph % 3) != 0;
        if (tx_valid && tx_ready) begin
            got[n[5:0]] <= tx_beat.data;
            n <= n + 1;
        end
    end
endmodule

// *** verification/mpfv_flow_ctl_test.sv ***
// Self-checking bench for the pause, flow and VLAN block
`timescale 1ns/10ps
module mpfv_flow_ctl_test;
    logic core_clk, rst, avs_read, avs_write, avs_waitrequest, rx_valid, addr_pass, promisc;
    logic rxo_valid, tx_valid, tx_ready, tx_halt, backpressure, mgmt_start, mgmt_done, txen, fdx, spd, mgmt_write;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [4:0] phy_a, reg_i;
    logic [15:0] mgmt_rdata, mgmt_wdata;
    mpfv_pkg::mpfv_rx_beat_t rx_beat, rxo_b;
    mpfv_pkg::mpfv_rx_stat_t rx_stat, st;
    mpfv_pkg::mpfv_tx_beat_t tx_beat;
    int n_fail = 0, total_checks = 0, cyc = 0, b;
    mpfv_flow_ctl #(.SLOT_CYC_10(20)) u_dut (.core_clk(core_clk), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid), .rx_beat(rx_beat),
        .addr_pass(addr_pass), .promisc(promisc), .rxo_valid(rxo_valid), .rxo_beat(rxo_b),
        .rx_stat(rx_stat), .mac_addr(48'h0200_0000_0001), .tx_valid(tx_valid), .tx_beat(tx_beat),
        .tx_ready(tx_ready), .tx_halt(tx_halt), .backpressure(backpressure), .tx_enable(txen),
        .full_duplex(fdx), .speed_100(spd), .mgmt_start(mgmt_start), .mgmt_write(mgmt_write),
        .mgmt_phy_addr(phy_a), .mgmt_reg_idx(reg_i), .mgmt_wdata(mgmt_wdata), .mgmt_done(mgmt_done),
        .mgmt_rdata(mgmt_rdata));
    mpfv_link_partner u_lp (.core_clk(core_clk), .tx_valid(tx_valid), .tx_beat(tx_beat),
        .tx_ready(tx_ready));
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task test_done;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            test_done;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task send(input logic [15:0] ty, input logic [15:0] pt, input int len);
        for (int i = 0; i < len; i++) begin
            @(posedge core_clk);
            rx_valid <= 1'b1;
            rx_beat <= '{i == 12 ? ty[15:8] : i == 13 ? ty[7:0] : i == 15 ? 8'h01 :
                i == 16 ? pt[15:8] : i == 17 ? pt[7:0] : 8'h00, i == 0, i == len - 1, 1'b0};
        end
        @(posedge core_clk);
        rx_valid <= 1'b0;
        do @(posedge core_clk); while (rx_stat.valid !== 1'b1);
        st = rx_stat;
    endtask
    task t_regs;
        rchk(8'h20, 32'h0);
        rchk(8'h24, 32'h0);
        rchk(8'h3C, 32'h0);
        bus(1'b1, 8'h1C, 32'hFFFF_FFFF);
        rchk(8'h1C, 32'h0000_FFFF);
        bus(1'b1, 8'h24, 32'h0000_8100);
        rchk(8'h24, 32'h0000_8100);
        bus(1'b1, 8'h18, 32'h0000_0841);
        do @(posedge core_clk); while (mgmt_start !== 1'b1);
        chk({27'h0, phy_a}, 32'h1);
        chk({mgmt_wdata, 10'h0, mgmt_write, reg_i}, 32'hFFFF_0001);
        rchk(8'h18, 32'h0000_0841);
        bus(1'b1, 8'h1C, 32'h0000_1111);
        rchk(8'h1C, 32'h0000_FFFF);
        mgmt_rdata <= 16'hBEEF;
        mgmt_done <= 1'b1;
        @(posedge core_clk);
        mgmt_done <= 1'b0;
        rchk(8'h1C, 32'h0000_BEEF);
        $display("test regs done");
    endtask
    task t_pause_tx;
        bus(1'b1, 8'h20, 32'h1234_0000);
        b = u_lp.n;
        bus(1'b1, 8'h40, 32'hB);
        do @(posedge core_clk); while (tx_valid !== 1'b1);
        rchk(8'h20, 32'h1234_0001);
        do @(posedge core_clk); while (u_lp.n != b + 60);
        rchk(8'h20, 32'h1234_0000);
        chk({24'h0, u_lp.got[6'(b)]}, 32'h01);
        chk({24'h0, u_lp.got[6'(b + 12)]}, 32'h88);
        chk({24'h0, u_lp.got[6'(b + 15)]}, 32'h01);
        chk({u_lp.got[6'(b + 16)], u_lp.got[6'(b + 17)]}, 32'h1234);
        bus(1'b1, 8'h40, 32'h0);
        bus(1'b1, 8'h40, 32'hA);
        repeat (10) @(posedge core_clk);
        chk(tx_valid, 1'b0);
        bus(1'b1, 8'h20, 32'h2);
        bus(1'b1, 8'h40, 32'h8);
        @(posedge core_clk);
        chk(backpressure, 1'b0);
        bus(1'b1, 8'h40, 32'h9);
        @(posedge core_clk);
        chk(backpressure, 1'b1);
        rchk(8'h20, 32'h3);
        bus(1'b1, 8'h40, 32'h0);
        $display("test pause_tx done");
    endtask
    task t_rx;
        bus(1'b1, 8'h20, 32'h6);
        bus(1'b1, 8'h40, 32'h3);
        send(16'h8808, 16'h2, 60);
        chk(st.filter, 1'b1);
        chk(rxo_valid, 1'b1);
        chk(rxo_b.eof, 1'b1);
        repeat (30) @(posedge core_clk);
        chk(tx_halt, 1'b1);
        repeat (20) @(posedge core_clk);
        chk(tx_halt, 1'b0);
        bus(1'b1, 8'h20, 32'h0);
        send(16'h8808, 16'h2, 60);
        chk(st.filter, 1'b0);
        chk(tx_halt, 1'b0);
        promisc <= 1'b1;
        send(16'h8100, 16'h0, 1522);
        chk(st.vlan, 1'b1);
        chk(st.filter, 1'b1);
        chk(st.too_long, 1'b0);
        send(16'h0800, 16'h0, 1519);
        chk(st.vlan, 1'b0);
        chk(st.too_long, 1'b1);
        bus(1'b1, 8'h20, 32'h2);
        bus(1'b1, 8'h40, 32'h7);
        @(posedge core_clk);
        chk({29'h0, spd, fdx, txen}, 32'h7);
        send(16'h8808, 16'h1, 60);
        repeat (1200) @(posedge core_clk);
        chk(tx_halt, 1'b1);
        repeat (100) @(posedge core_clk);
        chk(tx_halt, 1'b0);
        $display("test rx done");
    endtask
    initial begin
        {rst, avs_read, avs_write, rx_valid, addr_pass, promisc, mgmt_done} = 7'h40;
        avs_address = 8'h0;
        avs_writedata = 32'h0;
        mgmt_rdata = 16'h0;
        rx_beat = '0;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        t_regs;
        t_pause_tx;
        t_rx;
        test_done;
    end
endmodule
